/* design/scsc_chan_decode.v */
/*
 Decoder for one channel: turns the rate/framing word and the protocol
 word into effective settings. Assumes latched, stable inputs.
*/
`timescale 1ns/10ps
`default_nettype none
`include "scsc_map.vh"

module scsc_chan_decode (
  input wire [15:0] rate_frm,
  input wire [15:0] proto,
  output wire [7:0] eff_rate,
  output wire [7:0] eff_tx,
  output wire [7:0] eff_proto,
  output wire char_mask_msb,
  output wire tool_mode
);
  // Unset protocol word selects tool connection
  assign tool_mode = (proto == `SCSC_PROTO_TOOL);
  // Upper byte is rate, lower byte transmission bits
  assign eff_rate = tool_mode ? `SCSC_RATE_TOOL : rate_frm[15:8];
  // Tool mode ignores transmission bits 6:0 and uses fixed framing; bit 7 kept from the word
  assign eff_tx = tool_mode ? {rate_frm[`SCSC_TX_MOD], `SCSC_TOOL_TX}
                            : rate_frm[7:0];
  assign eff_proto = proto[7:0];
  // Seven-bit characters drop the eighth bit
  assign char_mask_msb = ~eff_tx[`SCSC_TX_DBIT];
endmodule
`default_nettype wire

/* design/scsc_map.vh */
/*
 Register map, field positions, reset values and codes of the serial
 channel switch configuration bank. Assumes inclusion by bare name.
*/
`ifndef SCSC_MAP_VH
`define SCSC_MAP_VH

// Byte addresses of the switch words and status
`define SCSC_ADDR_CHA_RATE_FRM 8'h00
`define SCSC_ADDR_CHA_PROTO 8'h04
`define SCSC_ADDR_CHB_RATE_FRM 8'h08
`define SCSC_ADDR_CHB_PROTO 8'h0C
`define SCSC_ADDR_STATION 8'h10
`define SCSC_ADDR_CTRL 8'h14
`define SCSC_ADDR_STATUS 8'h18
`define SCSC_ADDR_CHA_EFF 8'h1C
`define SCSC_ADDR_CHB_EFF 8'h20

// Switch word width and reset value (unset)
`define SCSC_WORD_W 16
`define SCSC_WORD_RST 16'h0000

// Transmission setting bit positions in the low byte
`define SCSC_TX_OPER 0
`define SCSC_TX_DBIT 1
`define SCSC_TX_PAR 2
`define SCSC_TX_ODD 3
`define SCSC_TX_STOP 4
`define SCSC_TX_SUM 5
`define SCSC_TX_WRUN 6
`define SCSC_TX_MOD 7

// Protocol code for tool connection
`define SCSC_PROTO_TOOL 16'h0000
// Tool-connection framing: independent, 8 data, parity odd, 1 stop,
// sum check on, write during run allowed (bit 7 taken from the word)
`define SCSC_TOOL_TX 7'h6E
// Rate code forced for a tool-connection channel
`define SCSC_RATE_TOOL 8'h00

// Control register bit: start pulse
`define SCSC_CTRL_START 0

// AXI responses
`define SCSC_RESP_OKAY 2'h0
`define SCSC_RESP_SLVERR 2'h2

`endif

/* design/scsc_top.v */
/*
 Serial channel switch configuration bank with AXI4-Lite slave.
 Assumes a single 125 MHz clock and a well-behaved AXI4-Lite master.
*/
// Operation
// - Word one: rate high, settings low
// - Word three: rate high, settings low
// - Five 16-bit words; protocols, station number
// - Unset interface runs tool-connection mode
// - Tool mode uses fixed default framing
// - Seven-bit characters ignore most significant bit
`timescale 1ns/10ps
`default_nettype none
`include "scsc_map.vh"

module scsc_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg started_r,
  output reg [7:0] a_rate_r,
  output reg [7:0] a_tx_r,
  output reg [7:0] a_proto_r,
  output reg a_mask_msb_r,
  output reg [7:0] b_rate_r,
  output reg [7:0] b_tx_r,
  output reg [7:0] b_proto_r,
  output reg b_mask_msb_r,
  output reg [15:0] station_r
);
  // Switch words, software side
  reg [15:0] sw_r [0:4];
  // Latched copies taken at startup
  reg [15:0] lat_r [0:4];
  reg [7:0] awaddr_r;
  reg aw_held_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_held_r;
  reg start_req_r;
  reg [31:0] rdata_nxt;
  reg rd_ok;
  reg wr_ok;
  wire [7:0] a_rate;
  wire [7:0] a_tx;
  wire [7:0] a_proto;
  wire a_mask;
  wire a_tool;
  wire [7:0] b_rate;
  wire [7:0] b_tx;
  wire [7:0] b_proto;
  wire b_mask;
  wire b_tool;
  wire wr_go;
  wire [2:0] wr_idx;
  integer i;
  integer j;

  // Channel decoders work on the latched words
  scsc_chan_decode u_dec_a (
    .rate_frm(lat_r[0]),
    .proto(lat_r[1]),
    .eff_rate(a_rate),
    .eff_tx(a_tx),
    .eff_proto(a_proto),
    .char_mask_msb(a_mask),
    .tool_mode(a_tool)
  );
  scsc_chan_decode u_dec_b (
    .rate_frm(lat_r[2]),
    .proto(lat_r[3]),
    .eff_rate(b_rate),
    .eff_tx(b_tx),
    .eff_proto(b_proto),
    .char_mask_msb(b_mask),
    .tool_mode(b_tool)
  );

  // Write fires once both address and data are held
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_idx = awaddr_r[4:2];

  // Decode of write target
  always @* begin
    wr_ok = 1'b0;
    case (awaddr_r)
      `SCSC_ADDR_CHA_RATE_FRM: wr_ok = 1'b1;
      `SCSC_ADDR_CHA_PROTO: wr_ok = 1'b1;
      `SCSC_ADDR_CHB_RATE_FRM: wr_ok = 1'b1;
      `SCSC_ADDR_CHB_PROTO: wr_ok = 1'b1;
      `SCSC_ADDR_STATION: wr_ok = 1'b1;
      `SCSC_ADDR_CTRL: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Write channels: accept address and data in any order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCSC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `SCSC_RESP_OKAY : `SCSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Switch word storage, 16 bits each, two byte lanes
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 5; i = i + 1) begin
        sw_r[i] <= `SCSC_WORD_RST;
      end
    end else if (wr_go && wr_ok && wr_idx < 3'h5) begin
      if (wstrb_r[0]) begin
        sw_r[wr_idx][7:0] <= wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        sw_r[wr_idx][15:8] <= wdata_r[15:8];
      end
    end
  end

  // Start request pulse from the control register
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_req_r <= 1'b0;
    end else begin
      start_req_r <= wr_go && (awaddr_r == `SCSC_ADDR_CTRL) &&
        wstrb_r[0] && wdata_r[`SCSC_CTRL_START];
    end
  end

  // Latch words once at startup; later words stay unapplied and reset clears them
  always @(posedge aclk) begin
    if (!aresetn) begin
      started_r <= 1'b0;
      for (j = 0; j < 5; j = j + 1) begin
        lat_r[j] <= `SCSC_WORD_RST;
      end
    end else if (start_req_r && !started_r) begin
      started_r <= 1'b1;
      for (j = 0; j < 5; j = j + 1) begin
        lat_r[j] <= sw_r[j];
      end
    end
  end

  // Effective settings registered onto outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      a_rate_r <= 8'h00;
      a_tx_r <= 8'h00;
      a_proto_r <= 8'h00;
      a_mask_msb_r <= 1'b0;
      b_rate_r <= 8'h00;
      b_tx_r <= 8'h00;
      b_proto_r <= 8'h00;
      b_mask_msb_r <= 1'b0;
      station_r <= 16'h0000;
    end else begin
      a_rate_r <= a_rate;
      a_tx_r <= a_tx;
      a_proto_r <= a_proto;
      a_mask_msb_r <= a_mask;
      b_rate_r <= b_rate;
      b_tx_r <= b_tx;
      b_proto_r <= b_proto;
      b_mask_msb_r <= b_mask;
      station_r <= lat_r[4];
    end
  end

  // Read decode; status shows startup and tool-mode flags
  always @* begin
    rdata_nxt = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `SCSC_ADDR_CHA_RATE_FRM: rdata_nxt = {16'h0000, sw_r[0]};
      `SCSC_ADDR_CHA_PROTO: rdata_nxt = {16'h0000, sw_r[1]};
      `SCSC_ADDR_CHB_RATE_FRM: rdata_nxt = {16'h0000, sw_r[2]};
      `SCSC_ADDR_CHB_PROTO: rdata_nxt = {16'h0000, sw_r[3]};
      `SCSC_ADDR_STATION: rdata_nxt = {16'h0000, sw_r[4]};
      `SCSC_ADDR_CTRL: rdata_nxt = 32'h00000000;
      `SCSC_ADDR_STATUS: rdata_nxt = {29'h00000000, b_tool, a_tool, started_r};
      `SCSC_ADDR_CHA_EFF: rdata_nxt = {7'h00, a_mask, a_proto, a_rate, a_tx};
      `SCSC_ADDR_CHB_EFF: rdata_nxt = {7'h00, b_mask, b_proto, b_rate, b_tx};
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel: one read at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_nxt;
        s_axi_rresp <= rd_ok ? `SCSC_RESP_OKAY : `SCSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/scsc_top_properties.sv */
/* Port checks of the switch bank, bound from the bench.
   Assumes the bank's own port names. */
`timescale 1ns/10ps
`default_nettype none
module scsc_top_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic started_r,
  input wire logic [7:0] a_tx_r,
  input wire logic a_mask_msb_r,
  input wire logic [7:0] b_tx_r,
  input wire logic b_mask_msb_r
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Seven-bit flag follows the data-length bit
  property p_mask_a;
    $past(aresetn) |-> a_mask_msb_r == !a_tx_r[1];
  endproperty
  a_mask_a: assert property (p_mask_a) else $error("chan a mask");
  property p_mask_b;
    $past(aresetn) |-> b_mask_msb_r == !b_tx_r[1];
  endproperty
  a_mask_b: assert property (p_mask_b) else $error("chan b mask");
  // Startup latch is taken once and then holds
  property p_start_hold;
    started_r |=> started_r;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start lost");
  property p_eff_hold;
    started_r && $past(started_r) |=> $stable(a_tx_r) && $stable(b_tx_r);
  endproperty
  a_eff_hold: assert property (p_eff_hold) else $error("settings moved");
  // Register bus answers
  property p_ar_take;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar_take: assert property (p_ar_take) else $error("no read answer");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read stuck");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read overlap");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write overlap");
  // Main scenarios reached
  c_start: cover property (started_r && $past(started_r));
  c_mask: cover property (a_mask_msb_r);
  c_write: cover property (s_axi_bvalid);
endmodule
`default_nettype wire

/* verification/tb.sv */
/* Bench for the switch bank: AXI4-Lite master tasks, startup cases.
   Assumes the design header on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "scsc_map.vh"
module tb;
  localparam logic [1:0] ok = `SCSC_RESP_OKAY;
  localparam logic [1:0] err = `SCSC_RESP_SLVERR;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire started_r, a_mask_msb_r, b_mask_msb_r;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] a_rate_r, a_tx_r, a_proto_r, b_rate_r, b_tx_r, b_proto_r;
  wire [15:0] station_r;
  int n_errors = 0, num_checks = 0, cyc = 0;
  scsc_top dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .started_r(started_r),
    .a_rate_r(a_rate_r),
    .a_tx_r(a_tx_r),
    .a_proto_r(a_proto_r),
    .a_mask_msb_r(a_mask_msb_r),
    .b_rate_r(b_rate_r),
    .b_tx_r(b_tx_r),
    .b_proto_r(b_proto_r),
    .b_mask_msb_r(b_mask_msb_r),
    .station_r(station_r)
  );
  // 125 MHz clock
  always #4 aclk = ~aclk;
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t saw %h exp %h", $time, g, e);
    end
  endtask
  // Verdict
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  // One bus transfer: write d, or read and expect d
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic pa, pw;
    pa = 1'b1;
    pw = w;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    while (pa || pw) begin
      @(posedge aclk);
      if (w ? s_axi_awready : s_axi_arready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    chk({30'h0, w ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
    if (!w) begin
      chk(s_axi_rdata, d);
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Applied settings of both channels
  task automatic eff(input logic [24:0] ea, input logic [24:0] eb);
    chk({7'h00, a_mask_msb_r, a_proto_r, a_rate_r, a_tx_r}, {7'h00, ea});
    chk({7'h00, b_mask_msb_r, b_proto_r, b_rate_r, b_tx_r}, {7'h00, eb});
  endtask
  // Clear words, both channels in tool framing
  task automatic t_reset;
    chk({31'h0, started_r}, 32'h0);
    for (int i = 0; i < 5; i++) acc(1'b0, 8'(4 * i), 32'h0, ok);
    acc(1'b0, `SCSC_ADDR_CTRL, 32'h0, ok);
    acc(1'b0, `SCSC_ADDR_STATUS, 32'h6, ok);
    acc(1'b0, `SCSC_ADDR_CHA_EFF, 32'h6E, ok);
    acc(1'b0, `SCSC_ADDR_CHB_EFF, 32'h6E, ok);
    acc(1'b0, 8'h24, 32'h0, err);
    eff(25'h6E, 25'h6E);
  endtask
  // Words keep the low half; bad targets refused; nothing applied yet
  task automatic t_regs;
    logic [15:0] v [5];
    v = '{16'h0B14, 16'h0006, 16'h0A27, 16'h0007, 16'h1234};
    for (int i = 0; i < 5; i++) acc(1'b1, 8'(4 * i), {16'hA5A5, v[i]}, ok);
    acc(1'b1, 8'h24, 32'hFFFF, err);
    acc(1'b1, `SCSC_ADDR_STATUS, 32'h7, err);
    for (int i = 0; i < 5; i++) acc(1'b0, 8'(4 * i), {16'h0, v[i]}, ok);
    eff(25'h6E, 25'h6E);
  endtask
  // Start latches and applies the words
  task automatic t_start;
    acc(1'b1, `SCSC_ADDR_CTRL, 32'h1, ok);
    while (!started_r) @(posedge aclk);
    repeat (2) @(posedge aclk);
    eff(25'h1060B14, 25'h0070A27);
    chk({16'h0, station_r}, 32'h1234);
    acc(1'b0, `SCSC_ADDR_STATUS, 32'h1, ok);
    acc(1'b0, `SCSC_ADDR_CHA_EFF, 32'h1060B14, ok);
    acc(1'b0, `SCSC_ADDR_CHB_EFF, 32'h0070A27, ok);
  endtask
  // Later words and starts leave applied settings alone
  task automatic t_relatch;
    acc(1'b1, 8'h00, 32'h0F02, ok);
    acc(1'b1, `SCSC_ADDR_CTRL, 32'h1, ok);
    repeat (4) @(posedge aclk);
    eff(25'h1060B14, 25'h0070A27);
    acc(1'b0, 8'h00, 32'h0F02, ok);
    s_axi_wstrb <= 4'h2;
    acc(1'b1, 8'h00, 32'h3355, ok);
    s_axi_wstrb <= 4'hF;
    acc(1'b0, 8'h00, 32'h3302, ok);
  endtask
  // One channel configured, the other left unset and cleared
  task automatic t_mixed;
    acc(1'b1, 8'h00, 32'h0527, ok);
    acc(1'b1, 8'h04, 32'h0001, ok);
    acc(1'b1, `SCSC_ADDR_CTRL, 32'h1, ok);
    while (!started_r) @(posedge aclk);
    repeat (2) @(posedge aclk);
    eff(25'h0010527, 25'h6E);
    acc(1'b0, `SCSC_ADDR_STATUS, 32'h5, ok);
  endtask
  // Reset, scenarios, mid-run reset, verdict
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_regs;
    t_start;
    t_relatch;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_mixed;
    tally_and_finish;
  end
endmodule
bind scsc_top scsc_top_props u_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .started_r(started_r),
  .a_tx_r(a_tx_r),
  .a_mask_msb_r(a_mask_msb_r),
  .b_tx_r(b_tx_r),
  .b_mask_msb_r(b_mask_msb_r)
);
`default_nettype wire
